// ---- hdl/bps_consts.vh ----
// Shared constants for the branch prediction and speculation block
`ifndef BPS_CONSTS_VH
`define BPS_CONSTS_VH

// ----------------------------------------
// Table geometry
// ----------------------------------------
`define BPS_BHT_ENTRIES 8192
`define BPS_BHT_IDX_W 13
`define BPS_GHR_W 13
`define BPS_BTC_ENTRIES 16
`define BPS_BTC_IDX_W 4
`define BPS_BTC_LINE_W 128
`define BPS_RAS_ENTRIES 16
`define BPS_RAS_PTR_W 4
`define BPS_MAX_BR 7
`define BPS_TAG_W 3
`define BPS_ADDR_W 32

// ----------------------------------------
// Reset values
// ----------------------------------------
`define BPS_CNT_RESET 2'h1
`define BPS_GHR_RESET 13'h0000
`define BPS_PC_RESET 32'hfffffff0

// ----------------------------------------
// Branch kinds presented by decode
// ----------------------------------------
`define BPS_KIND_NONE 3'h0
`define BPS_KIND_JMP 3'h1
`define BPS_KIND_JCC 3'h2
`define BPS_KIND_CALL 3'h3
`define BPS_KIND_RET 3'h4

`endif

// ---- hdl/bps_ras.v ----
// Return address stack: circular stack of return addresses
`timescale 1ns/10ps
`include "bps_consts.vh"

module bps_ras (
    // Clock and reset
    input wire core_clk,
    input wire rst_b,
    // Stack operations
    input wire push,
    input wire pop,
    input wire [`BPS_ADDR_W-1:0] push_addr,
    // Top of stack
    output wire [`BPS_ADDR_W-1:0] top_addr,
    output wire top_valid
);

    // Private copy of pushed addresses, never read from memory
    reg [`BPS_ADDR_W-1:0] stack_mem [0:`BPS_RAS_ENTRIES-1];
    reg [`BPS_RAS_PTR_W-1:0] ptr_q;
    reg [`BPS_RAS_PTR_W:0] depth_q;
    wire [`BPS_RAS_PTR_W-1:0] top_idx;

    assign top_idx = ptr_q - 4'h1;
    assign top_addr = stack_mem[top_idx];
    assign top_valid = (depth_q != 5'h00);

    // ----------------------------------------
    // Pointer and depth; overflow overwrites the oldest entry
    // ----------------------------------------
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ptr_q <= 4'h0;
            depth_q <= 5'h00;
        end else if (push && !pop) begin
            ptr_q <= ptr_q + 4'h1;
            if (depth_q != 5'h10) begin
                depth_q <= depth_q + 5'h01;
            end
        end else if (pop && !push && top_valid) begin
            ptr_q <= top_idx;
            depth_q <= depth_q - 5'h01;
        end
    end

    // Storage is write-only under clock, no reset needed
    always @(posedge core_clk) begin
        if (push && pop) begin
            stack_mem[top_idx] <= push_addr;
        end else if (push) begin
            stack_mem[ptr_q] <= push_addr;
        end
    end

endmodule

// ---- hdl/bps_btc.v ----
// Branch target cache: 16 lines of 16 instruction bytes, direct mapped
`timescale 1ns/10ps
`include "bps_consts.vh"

module bps_btc (
    // Clock and reset
    input wire core_clk,
    input wire rst_b,
    // Lookup
    input wire [`BPS_ADDR_W-1:0] look_addr,
    output wire hit,
    output wire [`BPS_BTC_LINE_W-1:0] line,
    // Fill from fetch
    input wire fill_vld,
    input wire [`BPS_ADDR_W-1:0] fill_addr,
    input wire [`BPS_BTC_LINE_W-1:0] fill_line
);

    // Index from bits [7:4], tag from the rest of the line address
    reg [`BPS_BTC_LINE_W-1:0] data_mem [0:`BPS_BTC_ENTRIES-1];
    reg [`BPS_ADDR_W-9:0] tag_mem [0:`BPS_BTC_ENTRIES-1];
    reg [`BPS_BTC_ENTRIES-1:0] vld_q;
    wire [`BPS_BTC_IDX_W-1:0] look_idx;
    wire [`BPS_BTC_IDX_W-1:0] fill_idx;

    assign look_idx = look_addr[7:4];
    assign fill_idx = fill_addr[7:4];
    assign hit = vld_q[look_idx] && (tag_mem[look_idx] == look_addr[`BPS_ADDR_W-1:8]);
    assign line = data_mem[look_idx];

    // ----------------------------------------
    // Valid bits cleared at reset
    // ----------------------------------------
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            vld_q <= 16'h0000;
        end else if (fill_vld) begin
            vld_q[fill_idx] <= 1'b1;
        end
    end

    // Line and tag storage
    always @(posedge core_clk) begin
        if (fill_vld) begin
            data_mem[fill_idx] <= fill_line;
            tag_mem[fill_idx] <= fill_addr[`BPS_ADDR_W-1:8];
        end
    end

endmodule

// ---- hdl/bps_core.v ----
// Branch prediction and speculation control: predictor, target select, in-flight tracking
`timescale 1ns/10ps
`include "bps_consts.vh"

// Function
// - Unconditional branch redirects fetch with no penalty
// - Conditional prediction via 8192-entry two-level table
// - Table learns outcomes, individual and correlated groups
// - No stored targets; decode adders compute them
// - All candidate targets computed, valid one selected
// - Taken hit delivers 16 bytes to buffer
// - Target cache holds 16 lines of 16 bytes
// - 16-entry return stack pushes post-CALL address
// - RET pops newest address and fetches there
// - Stack holds own copy, no memory read
// - Not-taken branch continues sequential fetch
// - Instructions past unresolved branch execute speculatively
// - No commit until older branches resolve
// - Mispredict unwinds and restores register state
// - Seven branches in flight; further ones stall
// - Condition unit resolves branches independently
module bps_core (
    // Clock and reset
    input wire core_clk,
    input wire rst_b,
    // Decode slots: two short decoders present candidate branches
    input wire dec_vld,
    input wire dec_sel,
    input wire [2:0] dec_kind,
    input wire [`BPS_ADDR_W-1:0] dec_pc0,
    input wire [`BPS_ADDR_W-1:0] dec_pc1,
    input wire [7:0] dec_len0,
    input wire [7:0] dec_len1,
    input wire [`BPS_ADDR_W-1:0] dec_disp0,
    input wire [`BPS_ADDR_W-1:0] dec_disp1,
    output wire dec_stall,
    // Branch handed to scheduler
    output reg br_issue_q,
    output reg [`BPS_TAG_W-1:0] br_tag_q,
    output reg br_pred_taken_q,
    // Fetch redirect
    output reg fetch_redir_q,
    output reg [`BPS_ADDR_W-1:0] fetch_addr_q,
    // Target cache to instruction buffer
    output reg ibuf_vld_q,
    output reg [`BPS_BTC_LINE_W-1:0] ibuf_bytes_q,
    input wire btc_fill_vld,
    input wire [`BPS_ADDR_W-1:0] btc_fill_addr,
    input wire [`BPS_BTC_LINE_W-1:0] btc_fill_line,
    // Branch condition unit resolution
    input wire res_vld,
    input wire [`BPS_TAG_W-1:0] res_tag,
    input wire res_taken,
    input wire [`BPS_ADDR_W-1:0] res_fallthru,
    input wire [`BPS_ADDR_W-1:0] res_target,
    // Speculation control toward retire
    output wire commit_ok,
    input wire [`BPS_TAG_W-1:0] commit_tag,
    output reg flush_q,
    output reg [`BPS_TAG_W-1:0] restore_tag_q,
    output wire [2:0] inflight_cnt
);

    // ----------------------------------------
    // Target adders and selection
    // ----------------------------------------
    // Both slots get their targets computed in parallel; only the slot
    // flagged by decode is used, so no target ever needs storing.
    wire [`BPS_ADDR_W-1:0] next0;
    wire [`BPS_ADDR_W-1:0] next1;
    wire [`BPS_ADDR_W-1:0] tgt0;
    wire [`BPS_ADDR_W-1:0] tgt1;
    wire [`BPS_ADDR_W-1:0] sel_pc;
    wire [`BPS_ADDR_W-1:0] sel_next;
    wire [`BPS_ADDR_W-1:0] sel_tgt;

    assign next0 = dec_pc0 + {24'h000000, dec_len0};
    assign next1 = dec_pc1 + {24'h000000, dec_len1};
    assign tgt0 = next0 + dec_disp0;
    assign tgt1 = next1 + dec_disp1;
    assign sel_pc = dec_sel ? dec_pc1 : dec_pc0;
    assign sel_next = dec_sel ? next1 : next0;
    assign sel_tgt = dec_sel ? tgt1 : tgt0;

    // ----------------------------------------
    // Two-level predictor: global history xor address
    // ----------------------------------------
    reg [1:0] bht_mem [0:`BPS_BHT_ENTRIES-1]; // Two-bit saturating counters
    reg [`BPS_GHR_W-1:0] ghr_q; // Speculative global history
    reg [`BPS_BHT_ENTRIES-1:0] bht_init_q; // Entry written since reset
    wire [`BPS_BHT_IDX_W-1:0] pred_idx;
    wire [1:0] pred_cnt;
    wire pred_taken;

    // Hashing in history lets correlated branches share patterns
    assign pred_idx = sel_pc[`BPS_BHT_IDX_W-1:0] ^ ghr_q;
    assign pred_cnt = bht_init_q[pred_idx] ? bht_mem[pred_idx] : `BPS_CNT_RESET;
    assign pred_taken = pred_cnt[1];

    // ----------------------------------------
    // In-flight branch tracking
    // ----------------------------------------
    reg [`BPS_MAX_BR-1:0] busy_q; // Slot holds an unresolved branch
    reg [`BPS_BHT_IDX_W-1:0] slot_idx_q [0:`BPS_MAX_BR-1]; // Table index used
    reg [`BPS_MAX_BR-1:0] slot_pred_q; // Predicted direction
    reg [`BPS_GHR_W-1:0] slot_ghr_q [0:`BPS_MAX_BR-1]; // History before branch
    reg [`BPS_TAG_W-1:0] free_tag;
    reg free_found;
    wire is_br;
    wire take_br;
    wire res_hit;
    wire mispred;
    integer k;

    // Lowest free slot; tags run 0..6 so seven is the ceiling
    always @* begin
        free_tag = 3'h0;
        free_found = 1'b0;
        for (k = `BPS_MAX_BR - 1; k >= 0; k = k - 1) begin
            if (!busy_q[k]) begin
                free_tag = k[2:0];
                free_found = 1'b1;
            end
        end
    end

    assign is_br = dec_vld && (dec_kind != `BPS_KIND_NONE);
    // Back-pressure: an eighth branch waits in decode
    assign dec_stall = is_br && !free_found;
    // Mispredict squashes the same-cycle decode
    assign take_br = is_br && free_found && !mispred;
    assign res_hit = res_vld && (res_tag != 3'h7) && busy_q[res_tag];
    assign mispred = res_hit && (res_taken != slot_pred_q[res_tag]);

    // Count for visibility to the scheduler
    assign inflight_cnt = {2'h0, busy_q[0]} + {2'h0, busy_q[1]} + {2'h0, busy_q[2]} +
                          {2'h0, busy_q[3]} + {2'h0, busy_q[4]} + {2'h0, busy_q[5]} +
                          {2'h0, busy_q[6]};

    // Commit allowed only when no branch other than the tag is pending
    assign commit_ok = (busy_q == 7'h00) ||
                       ((commit_tag != 3'h7) && (busy_q == (7'h01 << commit_tag)));

    // ----------------------------------------
    // Return address stack and target cache
    // ----------------------------------------
    wire ras_push;
    wire ras_pop;
    wire [`BPS_ADDR_W-1:0] ras_top;
    wire ras_valid;
    wire [`BPS_ADDR_W-1:0] btc_look;
    wire btc_hit;
    wire [`BPS_BTC_LINE_W-1:0] btc_line;

    // Only a decode that takes a tag moves the stack, so a stall cannot push twice
    assign ras_push = take_br && (dec_kind == `BPS_KIND_CALL);
    assign ras_pop = take_br && (dec_kind == `BPS_KIND_RET);

    bps_ras u_ras (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .push(ras_push),
        .pop(ras_pop),
        .push_addr(sel_next),
        .top_addr(ras_top),
        .top_valid(ras_valid)
    );

    // Lookup address is the predicted-taken target for this decode
    assign btc_look = (dec_kind == `BPS_KIND_RET) ? ras_top : sel_tgt;

    bps_btc u_btc (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .look_addr(btc_look),
        .hit(btc_hit),
        .line(btc_line),
        .fill_vld(btc_fill_vld),
        .fill_addr(btc_fill_addr),
        .fill_line(btc_fill_line)
    );

    // ----------------------------------------
    // Redirect decision
    // ----------------------------------------
    reg redir_d;
    reg [`BPS_ADDR_W-1:0] redir_addr_d;
    reg taken_d;

    always @* begin
        redir_d = 1'b0;
        redir_addr_d = sel_next;
        taken_d = 1'b0;
        if (mispred) begin
            // Correct path after a wrong guess
            redir_d = 1'b1;
            redir_addr_d = res_taken ? res_target : res_fallthru;
        end else if (dec_vld && free_found) begin
            case (dec_kind)
                `BPS_KIND_JMP, `BPS_KIND_CALL: begin
                    redir_d = 1'b1;
                    redir_addr_d = sel_tgt;
                    taken_d = 1'b1;
                end
                `BPS_KIND_RET: begin
                    // Empty stack: let decode fall back to the slow path
                    redir_d = ras_valid;
                    redir_addr_d = ras_top;
                    taken_d = ras_valid;
                end
                `BPS_KIND_JCC: begin
                    if (free_found) begin
                        redir_d = pred_taken;
                        redir_addr_d = sel_tgt;
                        taken_d = pred_taken;
                        // Not taken: no redirect, fetch runs on sequentially
                    end
                end
                default: begin
                    redir_d = 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Output and tracking registers
    // ----------------------------------------
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            fetch_redir_q <= 1'b0;
            fetch_addr_q <= `BPS_PC_RESET;
            ibuf_vld_q <= 1'b0;
            ibuf_bytes_q <= 128'h0;
            br_issue_q <= 1'b0;
            br_tag_q <= 3'h0;
            br_pred_taken_q <= 1'b0;
            flush_q <= 1'b0;
            restore_tag_q <= 3'h0;
            busy_q <= 7'h00;
            slot_pred_q <= 7'h00;
            ghr_q <= `BPS_GHR_RESET;
        end else begin
            fetch_redir_q <= redir_d;
            fetch_addr_q <= redir_addr_d;
            // Cached line saves the one-clock fetch on a taken hit
            ibuf_vld_q <= redir_d && !mispred && taken_d && btc_hit;
            ibuf_bytes_q <= btc_line;
            br_issue_q <= take_br;
            br_tag_q <= free_tag;
            br_pred_taken_q <= taken_d;
            flush_q <= mispred;
            restore_tag_q <= res_tag;
            if (mispred) begin
                // Drop every younger branch; simplest safe unwind is all of them
                busy_q <= 7'h00;
                ghr_q <= {slot_ghr_q[res_tag][`BPS_GHR_W-2:0], res_taken};
            end else begin
                if (res_hit) begin
                    busy_q[res_tag] <= 1'b0;
                end
                if (take_br) begin
                    busy_q[free_tag] <= 1'b1;
                    slot_pred_q[free_tag] <= taken_d;
                    if (dec_kind == `BPS_KIND_JCC) begin
                        ghr_q <= {ghr_q[`BPS_GHR_W-2:0], pred_taken};
                    end
                end
            end
        end
    end

    // Per-slot history snapshot and index, no reset needed
    always @(posedge core_clk) begin
        if (take_br) begin
            slot_idx_q[free_tag] <= pred_idx;
            slot_ghr_q[free_tag] <= ghr_q;
        end
    end

    // ----------------------------------------
    // Counter update on resolution
    // ----------------------------------------
    wire [`BPS_BHT_IDX_W-1:0] upd_idx;
    wire [1:0] upd_old;
    reg [1:0] upd_new;

    assign upd_idx = slot_idx_q[res_tag];
    assign upd_old = bht_init_q[upd_idx] ? bht_mem[upd_idx] : `BPS_CNT_RESET;

    always @* begin
        upd_new = upd_old;
        if (res_taken && (upd_old != 2'h3)) begin
            upd_new = upd_old + 2'h1;
        end else if (!res_taken && (upd_old != 2'h0)) begin
            upd_new = upd_old - 2'h1;
        end
    end

    always @(posedge core_clk) begin
        if (res_hit) begin
            bht_mem[upd_idx] <= upd_new;
        end
    end

    // Init flags make a reset of the large array unnecessary
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            bht_init_q <= {`BPS_BHT_ENTRIES{1'b0}};
        end else if (res_hit) begin
            bht_init_q[upd_idx] <= 1'b1;
        end
    end

endmodule

// ---- verif/bps_core_assertions.sv ----
// Assertion checker for the branch prediction and speculation core
`timescale 1ns/10ps
`include "bps_consts.vh"

module bps_chk (
    // Clock and reset
    input wire core_clk,
    input wire rst_b,
    // Decode slots
    input wire dec_vld,
    input wire dec_sel,
    input wire [2:0] dec_kind,
    input wire [31:0] dec_pc0,
    input wire [31:0] dec_pc1,
    input wire [7:0] dec_len0,
    input wire [7:0] dec_len1,
    input wire [31:0] dec_disp0,
    input wire [31:0] dec_disp1,
    input wire dec_stall,
    // Issue and fetch
    input wire br_issue_q,
    input wire br_pred_taken_q,
    input wire fetch_redir_q,
    input wire [31:0] fetch_addr_q,
    input wire ibuf_vld_q,
    // Resolution and speculation
    input wire res_vld,
    input wire res_taken,
    input wire [31:0] res_fallthru,
    input wire [31:0] res_target,
    input wire commit_ok,
    input wire flush_q,
    input wire [2:0] inflight_cnt
);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Target of the selected slot, as the adders should form it
    wire [31:0] tgt = dec_sel ? dec_pc1 + dec_len1 + dec_disp1 : dec_pc0 + dec_len0 + dec_disp0;
    // Correct path after a resolution
    wire [31:0] fix_addr = res_taken ? res_target : res_fallthru;
    // Accepted decode; a resolve cycle is left out since it may squash
    wire acc = dec_vld && dec_kind != `BPS_KIND_NONE && !dec_stall && !res_vld;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_jmp_target: assert property (acc && dec_kind == `BPS_KIND_JMP |=>
        fetch_redir_q && fetch_addr_q == $past(tgt))
        else $error("jump did not redirect to its target");
    a_issue_next: assert property (acc |=> br_issue_q)
        else $error("accepted branch not issued");
    a_stall_full: assert property (inflight_cnt == 3'h7 && dec_vld && dec_kind != `BPS_KIND_NONE
        |-> dec_stall)
        else $error("no stall with seven branches busy");
    a_stall_block: assert property (dec_stall |=> !br_issue_q)
        else $error("branch issued while stalled");
    a_jcc_fallthru: assert property (acc && dec_kind == `BPS_KIND_JCC ##1 !br_pred_taken_q
        |-> !fetch_redir_q)
        else $error("not-taken branch redirected fetch");
    a_flush_redir: assert property (flush_q |-> fetch_redir_q && fetch_addr_q == $past(fix_addr))
        else $error("mispredict did not refetch the correct path");
    a_flush_frees: assert property (flush_q |-> inflight_cnt == 3'h0)
        else $error("tags still busy after mispredict");
    a_commit_idle: assert property (inflight_cnt == 3'h0 |-> commit_ok)
        else $error("commit held with no branch busy");
    a_commit_block: assert property (inflight_cnt > 3'h1 |-> !commit_ok)
        else $error("commit allowed past unresolved branch");
    a_ibuf_taken: assert property (ibuf_vld_q |-> fetch_redir_q)
        else $error("cache line sent without taken redirect");

    // Main scenarios reached
    c_flush: cover property (flush_q);
    c_ibuf: cover property (ibuf_vld_q);
    c_stall: cover property (dec_stall && dec_vld);
endmodule

bind bps_core bps_chk bps_chk_inst (.core_clk, .rst_b, .dec_vld, .dec_sel, .dec_kind, .dec_pc0, .dec_pc1,
    .dec_len0, .dec_len1, .dec_disp0, .dec_disp1, .dec_stall, .br_issue_q, .br_pred_taken_q, .fetch_redir_q,
    .fetch_addr_q, .ibuf_vld_q, .res_vld, .res_taken, .res_fallthru, .res_target, .commit_ok, .flush_q,
    .inflight_cnt);

// ---- verif/bps_bcu_model.sv ----
// Branch condition unit model that resolves issued branches oldest first
`timescale 1ns/10ps

module bps_bcu_model (
    // Clock and reset
    input wire core_clk,
    input wire rst_b,
    // Issued branches and flush from the core
    input wire br_issue_q,
    input wire [2:0] br_tag_q,
    input wire flush_q,
    // Resolve command from the bench
    input wire go,
    input wire go_taken,
    input wire [31:0] go_ft,
    input wire [31:0] go_tgt,
    // Resolution toward the core
    output reg res_vld,
    output reg [2:0] res_tag,
    output reg res_taken,
    output reg [31:0] res_fallthru,
    output reg [31:0] res_target
);
    // Tags of branches still waiting, oldest first
    logic [2:0] busy_q[$];

    // ----------------------------------------
    // Resolve on command, separate from prediction
    // ----------------------------------------
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            busy_q.delete();
            res_vld <= 1'b0;
            res_tag <= 3'h0;
            res_taken <= 1'b0;
            res_fallthru <= 32'h0;
            res_target <= 32'h0;
        end else begin
            // A mispredict discards every younger branch
            if (flush_q) begin
                busy_q.delete();
            end else if (br_issue_q) begin
                busy_q.push_back(br_tag_q);
            end
            if (go && busy_q.size() > 0) begin
                res_vld <= 1'b1;
                res_tag <= busy_q.pop_front();
                res_taken <= go_taken;
                res_fallthru <= go_ft;
                res_target <= go_tgt;
            end else begin
                // Idle: fields churn so stale values never look valid
                res_vld <= 1'b0;
                res_tag <= ~res_tag;
                res_taken <= ~res_taken;
                res_fallthru <= ~res_fallthru;
                res_target <= ~res_target;
            end
        end
    end
endmodule

// ---- verif/bps_core_bench.sv ----
// Self-checking bench for the branch prediction and speculation core
`timescale 1ns/10ps
`include "bps_consts.vh"

module bps_core_bench;
    // Row of an ordinary decode case and what it should give
    typedef struct packed {
        logic [2:0] kind;
        logic sel;
        logic [31:0] pc;
        logic [7:0] len;
        logic [31:0] disp;
        logic red;
        logic [31:0] addr;
        logic hit;
    } bps_row_t;

    // Core inputs
    reg core_clk = 1'b0;
    reg rst_b = 1'b0;
    reg dec_vld = 1'b0;
    reg dec_sel = 1'b0;
    reg [2:0] dec_kind = 3'h0;
    reg [31:0] dec_pc0 = 32'h0;
    reg [31:0] dec_pc1 = 32'h0;
    reg [7:0] dec_len0 = 8'h0;
    reg [7:0] dec_len1 = 8'h0;
    reg [31:0] dec_disp0 = 32'h0;
    reg [31:0] dec_disp1 = 32'h0;
    reg btc_fill_vld = 1'b0;
    reg [31:0] btc_fill_addr = 32'h0;
    reg [127:0] btc_fill_line = 128'h0;
    reg [2:0] commit_tag = 3'h7;
    // Partner command
    reg go = 1'b0;
    reg go_taken = 1'b0;
    reg [31:0] go_ft = 32'h0;
    reg [31:0] go_tgt = 32'h0;
    // Core outputs and resolution
    wire dec_stall, br_issue_q, br_pred_taken_q, fetch_redir_q, ibuf_vld_q, commit_ok, flush_q;
    wire res_vld, res_taken;
    wire [2:0] br_tag_q, restore_tag_q, inflight_cnt, res_tag;
    wire [31:0] fetch_addr_q, res_fallthru, res_target;
    wire [127:0] ibuf_bytes_q;
    // Bench state
    bps_row_t rows [0:4];
    int i;
    int compares = 0;
    int n_mismatch = 0;
    localparam logic [127:0] LINE_C = 128'h0f1e2d3c4b5a69788796a5b4c3d2e1f0;

    // 10 MHz clock
    always #50 core_clk = ~core_clk;

    bps_core bps_core_inst (.core_clk, .rst_b, .dec_vld, .dec_sel, .dec_kind, .dec_pc0, .dec_pc1, .dec_len0,
        .dec_len1, .dec_disp0, .dec_disp1, .dec_stall, .br_issue_q, .br_tag_q, .br_pred_taken_q, .fetch_redir_q,
        .fetch_addr_q, .ibuf_vld_q, .ibuf_bytes_q, .btc_fill_vld, .btc_fill_addr, .btc_fill_line, .res_vld,
        .res_tag, .res_taken, .res_fallthru, .res_target, .commit_ok, .commit_tag, .flush_q, .restore_tag_q,
        .inflight_cnt);
    bps_bcu_model bps_bcu_model_inst (.core_clk, .rst_b, .br_issue_q, .br_tag_q, .flush_q, .go, .go_taken,
        .go_ft, .go_tgt, .res_vld, .res_tag, .res_taken, .res_fallthru, .res_target);

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(input string name, input logic [127:0] seen, input logic [127:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Present one branch for a cycle; the unused slot carries junk
    task automatic dec(input logic [2:0] k, input logic s, input logic [31:0] pc, input logic [7:0] ln,
            input logic [31:0] d);
        @(posedge core_clk);
        dec_vld <= 1'b1;
        dec_kind <= k;
        dec_sel <= s;
        dec_pc0 <= s ? ~pc : pc;
        dec_pc1 <= s ? pc : ~pc;
        dec_len0 <= s ? ~ln : ln;
        dec_len1 <= s ? ln : ~ln;
        dec_disp0 <= s ? ~d : d;
        dec_disp1 <= s ? d : ~d;
        @(posedge core_clk);
        dec_vld <= 1'b0;
        #1;
    endtask

    // Resolve the oldest branch; core answers two edges later
    task automatic res(input logic t, input logic [31:0] ft, input logic [31:0] tg);
        @(posedge core_clk);
        go <= 1'b1;
        go_taken <= t;
        go_ft <= ft;
        go_tgt <= tg;
        @(posedge core_clk);
        go <= 1'b0;
        @(posedge core_clk);
        #1;
    endtask

    task automatic results;
        $display("Checks %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Watchdog cuts a hang short
    initial begin
        repeat (5000) @(posedge core_clk);
        n_mismatch++;
        results;
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        rows[0] = '{`BPS_KIND_JMP, 1'b0, 32'h00001000, 8'h02, 32'h00000ffe, 1'b1, 32'h00002000, 1'b1};
        rows[1] = '{`BPS_KIND_JMP, 1'b1, 32'h00003000, 8'h05, 32'h0000000b, 1'b1, 32'h00003010, 1'b0};
        rows[2] = '{`BPS_KIND_JCC, 1'b0, 32'h00004000, 8'h02, 32'h00000010, 1'b0, 32'h00004012, 1'b0};
        rows[3] = '{`BPS_KIND_CALL, 1'b1, 32'h00005000, 8'h05, 32'h00000100, 1'b1, 32'h00005105, 1'b0};
        rows[4] = '{`BPS_KIND_RET, 1'b0, 32'h00006000, 8'h01, 32'h00000000, 1'b1, 32'h00005005, 1'b0};
        repeat (10) @(posedge core_clk);
        rst_b <= 1'b1;
        #1;
        chk("fetch_addr_q", fetch_addr_q, 32'hfffffff0);
        chk("commit_ok", commit_ok, 1'b1);
        chk("dec_stall", dec_stall, 1'b0);
        // Load one target line so the first jump hits
        @(posedge core_clk);
        btc_fill_vld <= 1'b1;
        btc_fill_addr <= 32'h00002000;
        btc_fill_line <= LINE_C;
        @(posedge core_clk);
        btc_fill_vld <= 1'b0;
        // Ordinary cases, each resolved the way it was predicted
        for (i = 0; i < 5; i++) begin
            dec(rows[i].kind, rows[i].sel, rows[i].pc, rows[i].len, rows[i].disp);
            chk("br_issue_q", br_issue_q, 1'b1);
            chk("br_pred_taken_q", br_pred_taken_q, rows[i].red);
            chk("commit_ok", commit_ok, 1'b0);
            chk("fetch_redir_q", fetch_redir_q, rows[i].red);
            if (rows[i].red)
                chk("fetch_addr_q", fetch_addr_q, rows[i].addr);
            chk("ibuf_vld_q", ibuf_vld_q, rows[i].hit);
            if (rows[i].hit)
                chk("ibuf_bytes_q", ibuf_bytes_q, LINE_C);
            res(rows[i].red, rows[i].pc + rows[i].len, rows[i].addr);
            chk("flush_q", flush_q, 1'b0);
            chk("inflight_cnt", inflight_cnt, 3'h0);
        end
        // Seven branches, one every other cycle, fill every tag; their table entries are untrained
        for (i = 0; i < 7; i++) begin
            dec(`BPS_KIND_JCC, 1'b0, 32'h00007800 + i * 16, 8'h02, 32'h00000020);
            chk("br_tag_q", br_tag_q, i[2:0]);
            chk("br_pred_taken_q", br_pred_taken_q, 1'b0);
        end
        chk("inflight_cnt", inflight_cnt, 3'h7);
        chk("commit_ok", commit_ok, 1'b0);
        // An eighth branch is held back while every tag is busy
        @(posedge core_clk);
        dec_vld <= 1'b1;
        dec_pc0 <= 32'h00008000;
        #1;
        chk("dec_stall", dec_stall, 1'b1);
        @(posedge core_clk);
        dec_vld <= 1'b0;
        #1;
        chk("br_issue_q", br_issue_q, 1'b0);
        chk("fetch_redir_q", fetch_redir_q, 1'b0);
        // Oldest branch turns out taken: unwind and refetch
        res(1'b1, 32'h00007802, 32'h00007822);
        chk("flush_q", flush_q, 1'b1);
        chk("restore_tag_q", restore_tag_q, 3'h0);
        chk("fetch_redir_q", fetch_redir_q, 1'b1);
        chk("fetch_addr_q", fetch_addr_q, 32'h00007822);
        chk("inflight_cnt", inflight_cnt, 3'h0);
        chk("commit_ok", commit_ok, 1'b1);
        results;
    end
endmodule
